// ---- src/mafb_defs.vh ----
// constants for the accumulator alu, flag and bit-operation block
`ifndef MAFB_DEFS_VH
`define MAFB_DEFS_VH
// =====================================
// register byte offsets
`define MAFB_OFS_INSTR 10'h000
`define MAFB_OFS_ACC 10'h004
`define MAFB_OFS_FLAGS 10'h008
`define MAFB_OFS_IRQ_STAT 10'h00C
`define MAFB_OFS_IRQ_CLR 10'h010
`define MAFB_OFS_IRQ_EN 10'h014
`define MAFB_OFS_RPAGE 10'h100
// =====================================
// instruction word fields
`define MAFB_F_OP_HI 3
`define MAFB_F_OP_LO 0
`define MAFB_F_DEST 4
`define MAFB_F_BIT_HI 7
`define MAFB_F_BIT_LO 5
`define MAFB_F_REG_HI 13
`define MAFB_F_REG_LO 8
`define MAFB_F_IMM_HI 23
`define MAFB_F_IMM_LO 16
// =====================================
// flag register bit positions
`define MAFB_FL_C 0
`define MAFB_FL_DC 1
`define MAFB_FL_Z 2
`define MAFB_FL_PD 3
`define MAFB_FL_TO 4
// interrupt status bit positions
`define MAFB_IRQ_DONE 0
`define MAFB_IRQ_ZERO 1
`define MAFB_IRQ_CARRY 2
`define MAFB_IRQ_WDTO 3
`define MAFB_IRQ_W 4
// =====================================
// operation codes
`define MAFB_OP_ADD_REG 4'h0
`define MAFB_OP_ADC_REG 4'h1
`define MAFB_OP_ADD_IMM 4'h2
`define MAFB_OP_ADC_IMM 4'h3
`define MAFB_OP_AND_REG 4'h4
`define MAFB_OP_AND_IMM 4'h5
`define MAFB_OP_BIT_CLR 4'h6
`define MAFB_OP_BIT_SET 4'h7
`define MAFB_OP_SUB_REG 4'h8
`define MAFB_OP_SUB_IMM 4'h9
`define MAFB_OP_WDT_CLR 4'hA
`define MAFB_OP_SLEEP 4'hB
// =====================================
// reset values
`define MAFB_RST_ACC 8'h00
`define MAFB_RST_INSTR 32'h00000000
`define MAFB_RST_IRQ_EN 4'h0
`endif

// ---- src/mafb_regfile.v ----
// R-page register array, 64 bytes, two read ports
`timescale 1ns/1ns
module mafb_regfile #(
  parameter AW = 6,
  parameter DW = 8
) (
  // clock
  input wire mclk,
  // write port
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  // read ports
  input wire [AW-1:0] raddr_a,
  output wire [DW-1:0] rdata_a,
  input wire [AW-1:0] raddr_b,
  output wire [DW-1:0] rdata_b
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  // =====================================
  // storage, no reset: contents undefined at power-up
  always @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
  // asynchronous reads so an instruction completes in one edge
  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];
endmodule // mafb_regfile

// ---- src/mafb_alu.v ----
// combinational adder, and, bit set and bit clear unit
`timescale 1ns/1ns
`include "mafb_defs.vh"
module mafb_alu (
  // operation
  input wire [3:0] op,
  input wire [2:0] bit_sel,
  // operands
  input wire [7:0] acc,
  input wire [7:0] rval,
  input wire [7:0] imm,
  input wire carry_in,
  // result
  output reg [7:0] result,
  output reg carry_out,
  output reg dc_out,
  output wire zero_out,
  output reg upd_arith,
  output reg upd_zero
);
  wire [7:0] bit_mask;
  reg [7:0] opa;
  reg [7:0] opb;
  reg cin;
  wire [4:0] low_sum;
  wire [8:0] full_sum;
  // =====================================
  // one-hot mask of the selected bit
  genvar k;
  generate
    for (k = 0; k < 8; k = k + 1) begin : g_mask
      assign bit_mask[k] = (bit_sel == k);
    end
  endgenerate
  // shared adder; subtraction reuses it with inverted accumulator
  assign low_sum = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
  assign full_sum = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
  assign zero_out = (result == 8'h00);
  // =====================================
  // operand routing and result select
  always @* begin
    opa = rval;
    opb = acc;
    cin = 1'b0;
    result = 8'h00;
    upd_arith = 1'b0;
    upd_zero = 1'b0;
    case (op)
      `MAFB_OP_ADD_REG: begin
        upd_arith = 1'b1;
      end
      `MAFB_OP_ADC_REG: begin
        cin = carry_in;
        upd_arith = 1'b1;
      end
      `MAFB_OP_ADD_IMM: begin
        opa = imm;
        upd_arith = 1'b1;
      end
      `MAFB_OP_ADC_IMM: begin
        opa = imm;
        cin = carry_in;
        upd_arith = 1'b1;
      end
      `MAFB_OP_SUB_REG: begin
        opb = ~acc;
        cin = 1'b1;
        upd_arith = 1'b1;
      end
      `MAFB_OP_SUB_IMM: begin
        opa = imm;
        opb = ~acc;
        cin = 1'b1;
        upd_arith = 1'b1;
      end
      default: begin
        upd_arith = 1'b0;
      end
    endcase
    result = full_sum[7:0];
    case (op)
      `MAFB_OP_AND_REG: begin
        result = acc & rval;
        upd_zero = 1'b1;
      end
      `MAFB_OP_AND_IMM: begin
        result = acc & imm;
        upd_zero = 1'b1;
      end
      `MAFB_OP_BIT_CLR: result = rval & ~bit_mask;
      `MAFB_OP_BIT_SET: result = rval | bit_mask;
      default: upd_zero = upd_arith;
    endcase
    carry_out = full_sum[8];
    dc_out = low_sum[4];
  end
endmodule // mafb_alu

// ---- src/mafb_exec.v ----
// execution datapath with flags, R page, watchdog status and avalon slave
`timescale 1ns/1ns
`include "mafb_defs.vh"
module mafb_exec (
  // clock and reset
  input wire mclk,
  input wire rst,
  // avalon-mm slave
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // watchdog and sleep logic
  input wire wdt_timeout,
  output reg sleep_req,
  output reg watchdog_clear_req,
  // status
  output reg [7:0] acc_out,
  output reg power_down_flag,
  output reg timeout_flag,
  output reg irq
);
  // registers
  reg [31:0] instr_q;
  reg [7:0] acc_q;
  reg carry_q;
  reg digit_carry_flag_q;
  reg zero_q;
  reg pd_q;
  reg to_q;
  reg [3:0] irq_stat_q;
  reg [3:0] irq_en_q;
  reg [3:0] irq_stat_d;
  // bus helpers
  wire [31:0] be_mask;
  wire commit;
  wire wr_commit;
  wire [9:0] word_addr;
  wire rpage_hit;
  // execution helpers
  wire [31:0] instr_new;
  wire exec_fire;
  wire [3:0] op;
  wire dest_bit;
  wire [2:0] bit_sel;
  wire [5:0] reg_sel;
  wire [7:0] imm;
  wire [7:0] rval;
  wire [7:0] rval_bus;
  wire [7:0] alu_res;
  wire alu_c;
  wire alu_dc;
  wire alu_z;
  wire upd_arith;
  wire upd_zero;
  wire to_acc;
  wire to_reg;
  wire rf_we;
  wire [5:0] rf_waddr;
  wire [7:0] rf_wdata;
  wire [7:0] flags_rd;
  reg [31:0] rd_d;
  // interrupt event helpers
  wire ev_zero;
  wire ev_carry;
  wire stat_clr;

  // =====================================
  // decode helpers
  // operations whose result may go back to the register
  function dest_capable;
    input [3:0] f_op;
    begin
      dest_capable = (f_op == `MAFB_OP_ADD_REG) || (f_op == `MAFB_OP_ADC_REG) ||
        (f_op == `MAFB_OP_AND_REG) || (f_op == `MAFB_OP_SUB_REG);
    end
  endfunction

  // operations that always write the register
  function is_bit_op;
    input [3:0] f_op;
    begin
      is_bit_op = (f_op == `MAFB_OP_BIT_CLR) || (f_op == `MAFB_OP_BIT_SET);
    end
  endfunction

  // operations producing an accumulator result only
  function is_imm_op;
    input [3:0] f_op;
    begin
      is_imm_op = (f_op == `MAFB_OP_ADD_IMM) || (f_op == `MAFB_OP_ADC_IMM) ||
        (f_op == `MAFB_OP_AND_IMM) || (f_op == `MAFB_OP_SUB_IMM);
    end
  endfunction

  // completing write to one byte register; lane 0 carries its data
  function byte_wr;
    input f_wr;
    input [9:0] f_word;
    input [9:0] f_ofs;
    input f_lane0;
    begin
      byte_wr = f_wr & (f_word == f_ofs) & f_lane0;
    end
  endfunction

  // =====================================
  // avalon handshake
  // byte lanes turned into a bit mask for merging
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign word_addr = {avs_address[9:2], 2'b00};
  // the request completes at the edge that sees waitrequest low
  assign commit = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_commit = avs_write & ~avs_waitrequest;
  // page base as a full address so its top bits select without a shift
  localparam [9:0] RPAGE_BASE = `MAFB_OFS_RPAGE;
  assign rpage_hit = (word_addr[9:8] == RPAGE_BASE[9:8]);

  // one wait cycle per access: low for one cycle, then high again
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read | avs_write) & avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // =====================================
  // instruction issue
  // merged word so a partial write still issues a full instruction
  assign instr_new = (instr_q & ~be_mask) | (avs_writedata & be_mask);
  assign exec_fire = wr_commit & (word_addr == `MAFB_OFS_INSTR) & (|avs_byteenable);
  assign op = instr_new[`MAFB_F_OP_HI:`MAFB_F_OP_LO];
  assign dest_bit = instr_new[`MAFB_F_DEST];
  assign bit_sel = instr_new[`MAFB_F_BIT_HI:`MAFB_F_BIT_LO];
  assign reg_sel = instr_new[`MAFB_F_REG_HI:`MAFB_F_REG_LO];
  assign imm = instr_new[`MAFB_F_IMM_HI:`MAFB_F_IMM_LO];

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      instr_q <= `MAFB_RST_INSTR;
    end else if (exec_fire) begin
      instr_q <= instr_new;
    end
  end

  // =====================================
  // datapath instances
  mafb_alu u_alu (
    .op(op),
    .bit_sel(bit_sel),
    .acc(acc_q),
    .rval(rval),
    .imm(imm),
    .carry_in(carry_q),
    .result(alu_res),
    .carry_out(alu_c),
    .dc_out(alu_dc),
    .zero_out(alu_z),
    .upd_arith(upd_arith),
    .upd_zero(upd_zero)
  );

  mafb_regfile #(
    .AW(6),
    .DW(8)
  ) u_rf (
    .mclk(mclk),
    .we(rf_we),
    .waddr(rf_waddr),
    .wdata(rf_wdata),
    .raddr_a(reg_sel),
    .rdata_a(rval),
    .raddr_b(avs_address[7:2]),
    .rdata_b(rval_bus)
  );

  // =====================================
  // destination select
  // d low targets accumulator
  assign to_acc = exec_fire & ((dest_capable(op) & ~dest_bit) | is_imm_op(op));
  assign to_reg = exec_fire & ((dest_capable(op) & dest_bit) | is_bit_op(op));
  // execution and bus never commit in the same edge
  assign rf_we = to_reg | (wr_commit & rpage_hit & avs_byteenable[0]);
  assign rf_waddr = to_reg ? reg_sel : avs_address[7:2];
  assign rf_wdata = to_reg ? alu_res : avs_writedata[7:0];

  // accumulator: written by instruction or directly by software
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_q <= `MAFB_RST_ACC;
    end else if (to_acc) begin
      acc_q <= alu_res;
    end else if (byte_wr(wr_commit, word_addr, `MAFB_OFS_ACC, avs_byteenable[0])) begin
      acc_q <= avs_writedata[7:0];
    end
  end

  // =====================================
  // arithmetic flags
  // bit ops and illegal codes leave every flag alone
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      carry_q <= 1'b0;
      digit_carry_flag_q <= 1'b0;
      zero_q <= 1'b0;
    end else if (exec_fire) begin
      if (upd_arith) begin
        carry_q <= alu_c;
        digit_carry_flag_q <= alu_dc;
      end
      if (upd_zero) begin
        zero_q <= alu_z;
      end
    end else if (byte_wr(wr_commit, word_addr, `MAFB_OFS_FLAGS, avs_byteenable[0])) begin
      carry_q <= avs_writedata[`MAFB_FL_C];
      digit_carry_flag_q <= avs_writedata[`MAFB_FL_DC];
      zero_q <= avs_writedata[`MAFB_FL_Z];
    end
  end

  // =====================================
  // power-down and timeout flags, set to 1 at power-up
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pd_q <= 1'b1;
      to_q <= 1'b1;
    end else begin
      if (exec_fire & (op == `MAFB_OP_WDT_CLR)) begin
        pd_q <= 1'b1;
      end else if (exec_fire & (op == `MAFB_OP_SLEEP)) begin
        pd_q <= 1'b0;
      end
      // a real timeout outranks a same-cycle clear
      if (wdt_timeout) begin
        to_q <= 1'b0;
      end else if (exec_fire & ((op == `MAFB_OP_WDT_CLR) | (op == `MAFB_OP_SLEEP))) begin
        to_q <= 1'b1;
      end
    end
  end

  // one-cycle requests towards the watchdog and sleep logic
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      sleep_req <= 1'b0;
      watchdog_clear_req <= 1'b0;
    end else begin
      sleep_req <= exec_fire & (op == `MAFB_OP_SLEEP);
      watchdog_clear_req <= exec_fire & (op == `MAFB_OP_WDT_CLR);
    end
  end

  // status events; zero and carry only from ops that update those flags
  assign ev_zero = exec_fire & upd_zero & alu_z;
  assign ev_carry = exec_fire & upd_arith & alu_c;
  assign stat_clr = byte_wr(wr_commit, word_addr, `MAFB_OFS_IRQ_CLR, avs_byteenable[0]);

  // =====================================
  // interrupt status, set wins over clear
  always @* begin
    irq_stat_d = irq_stat_q;
    if (stat_clr) begin
      irq_stat_d = irq_stat_q & ~avs_writedata[`MAFB_IRQ_W-1:0];
    end
    if (exec_fire) begin
      irq_stat_d[`MAFB_IRQ_DONE] = 1'b1;
    end
    if (ev_zero) begin
      irq_stat_d[`MAFB_IRQ_ZERO] = 1'b1;
    end
    if (ev_carry) begin
      irq_stat_d[`MAFB_IRQ_CARRY] = 1'b1;
    end
    if (wdt_timeout) begin
      irq_stat_d[`MAFB_IRQ_WDTO] = 1'b1;
    end
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_stat_q <= 4'h0;
      irq_en_q <= `MAFB_RST_IRQ_EN;
    end else begin
      irq_stat_q <= irq_stat_d;
      if (byte_wr(wr_commit, word_addr, `MAFB_OFS_IRQ_EN, avs_byteenable[0])) begin
        irq_en_q <= avs_writedata[`MAFB_IRQ_W-1:0];
      end
    end
  end

  // =====================================
  // read data mux; unmapped words read as zero
  assign flags_rd = {3'b000, to_q, pd_q, zero_q, digit_carry_flag_q, carry_q};

  always @* begin
    rd_d = 32'h00000000;
    if (rpage_hit) begin
      rd_d = {24'h000000, rval_bus};
    end else begin
      case (word_addr)
        `MAFB_OFS_INSTR: rd_d = instr_q;
        `MAFB_OFS_ACC: rd_d = {24'h000000, acc_q};
        `MAFB_OFS_FLAGS: rd_d = {24'h000000, flags_rd};
        `MAFB_OFS_IRQ_STAT: rd_d = {28'h0000000, irq_stat_q};
        `MAFB_OFS_IRQ_EN: rd_d = {28'h0000000, irq_en_q};
        default: rd_d = 32'h00000000;
      endcase
    end
  end

  // read data captured in the wait cycle, valid at the completing edge
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & avs_waitrequest) begin
      avs_readdata <= rd_d;
    end
  end

  // =====================================
  // registered status outputs
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_out <= `MAFB_RST_ACC;
      power_down_flag <= 1'b1;
      timeout_flag <= 1'b1;
      irq <= 1'b0;
    end else begin
      acc_out <= acc_q;
      power_down_flag <= pd_q;
      timeout_flag <= to_q;
      irq <= |(irq_stat_q & irq_en_q);
    end
  end
endmodule // mafb_exec

// ---- testbench/mafb_exec_asserts.sv ----
// port checker for the execution block
`timescale 1ns/1ns
module mafb_exec_asserts (
  // clock and reset
  input wire mclk,
  input wire rst,
  // bus
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire avs_waitrequest,
  // watchdog side
  input wire wdt_timeout,
  input wire sleep_req,
  input wire watchdog_clear_req,
  // status
  input wire [7:0] acc_out,
  input wire power_down_flag,
  input wire timeout_flag
);
  // ====================
  // single domain, reset disables all
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_reset_state: assert property ($fell(rst) |-> avs_waitrequest && power_down_flag && timeout_flag
    && acc_out == 8'h00 && !sleep_req && !watchdog_clear_req) else $error("bad state after reset");
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  a_idle_wait: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest low without request");
  a_sleep_cause: assert property (sleep_req |-> $past(avs_write) && $past(avs_address) == 10'h000
    && $past(avs_writedata[3:0]) == 4'hB) else $error("sleep pulse without sleep instruction");
  a_clear_cause: assert property (watchdog_clear_req |-> $past(avs_write)
    && $past(avs_address) == 10'h000 && $past(avs_writedata[3:0]) == 4'hA) else $error("stray clear pulse");
  a_sleep_pd: assert property (sleep_req |-> ##[0:1] !power_down_flag)
    else $error("power-down flag not cleared by sleep");
  a_clear_pd: assert property (watchdog_clear_req |-> ##[0:1] power_down_flag)
    else $error("power-down flag not set by clear");
  a_sleep_to: assert property (sleep_req && !wdt_timeout && !$past(wdt_timeout) |-> ##[0:1] timeout_flag)
    else $error("timeout flag not set by sleep");
  a_timeout_to: assert property (wdt_timeout && !avs_write |-> ##[1:2] !timeout_flag)
    else $error("timeout flag not cleared by timeout");
  a_pulse_once: assert property (sleep_req |=> !sleep_req)
    else $error("sleep pulse longer than one cycle");
endmodule // mafb_exec_asserts

bind mafb_exec mafb_exec_asserts u_mafb_exec_asserts (.mclk(mclk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .wdt_timeout(wdt_timeout), .sleep_req(sleep_req), .watchdog_clear_req(watchdog_clear_req),
  .acc_out(acc_out), .power_down_flag(power_down_flag), .timeout_flag(timeout_flag));

// ---- testbench/mafb_wdt_model.sv ----
// watchdog and sleep logic model facing the execution block
`timescale 1ns/1ns
module mafb_wdt_model (
  // clock and reset
  input wire mclk,
  input wire rst,
  // bench command
  input wire fire,
  // block side
  input wire sleep_req,
  input wire watchdog_clear_req,
  output reg wdt_timeout,
  // event counts
  output reg [7:0] n_sleep,
  output reg [7:0] n_clear
);
  // timeout event source
  // counter not modelled: bench decides when it expires
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      wdt_timeout <= 1'b0;
      n_sleep <= 8'h00;
      n_clear <= 8'h00;
    end else begin
      wdt_timeout <= fire;
      n_sleep <= n_sleep + {7'h00, sleep_req};
      n_clear <= n_clear + {7'h00, watchdog_clear_req};
    end
  end
endmodule // mafb_wdt_model

// ---- testbench/mcu_alu_flag_bitop_exec_test.sv ----
// self-checking bench for the execution block
`timescale 1ns/1ns
module mcu_alu_flag_bitop_exec_test;
  reg mclk, rst, avs_read, avs_write, fire;
  reg [9:0] avs_address;
  reg [3:0] avs_byteenable;
  reg [31:0] avs_writedata, rd;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, wdt_timeout, sleep_req, watchdog_clear_req, power_down_flag, timeout_flag, irq;
  wire [7:0] acc_out, n_sleep, n_clear;
  integer n_mismatch, checked, cycles, i;

  // ====================
  // design and partner
  mafb_exec u_mafb_exec (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wdt_timeout(wdt_timeout),
    .sleep_req(sleep_req), .watchdog_clear_req(watchdog_clear_req), .acc_out(acc_out),
    .power_down_flag(power_down_flag), .timeout_flag(timeout_flag), .irq(irq));
  mafb_wdt_model u_mafb_wdt_model (.mclk(mclk), .rst(rst), .fire(fire), .sleep_req(sleep_req),
    .watchdog_clear_req(watchdog_clear_req), .wdt_timeout(wdt_timeout), .n_sleep(n_sleep), .n_clear(n_clear));

  // 25 MHz clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // hang guard, far above the expected run
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      report_and_stop;
    end
  end

  task report_and_stop;
    begin
      $display("mismatches %0d comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask

  task check(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask

  // one access; an idle edge after it keeps strobes from toggling twice
  task bus(input wr, input [9:0] a, input [31:0] d);
    begin
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0) @(posedge mclk);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge mclk);
    end
  endtask

  task exec(input [3:0] op, input d, input [2:0] bt, input [5:0] rn, input [7:0] imm);
    bus(1'b1, 10'h000, {8'h00, imm, 2'b00, rn, bt, d, op});
  endtask

  // preload acc, register and flags, run one instruction, judge all three
  task run_op(input [3:0] op, input d, input [2:0] bt, input [5:0] rn, input [7:0] a, r, imm, input [2:0] fl);
    reg [7:0] b, res, ea;
    reg [8:0] s;
    reg [4:0] lo;
    reg [2:0] nf, mask;
    reg isi, to_acc;
    begin
      isi = op == 4'h2 || op == 4'h3 || op == 4'h5 || op == 4'h9;
      b = isi ? imm : r;
      s = op[3] ? {1'b0, b} + {1'b0, ~a} + 9'h001 : {1'b0, a} + {1'b0, b} + {8'h00, op[0] & fl[0]};
      lo = op[3] ? {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01 : {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, op[0] & fl[0]};
      res = s[7:0];
      nf = {s[7:0] == 8'h00, lo[4], s[8]};
      mask = op[3] ? 3'b101 : 3'b111;
      if (op == 4'h4 || op == 4'h5) begin
        res = a & b;
        nf = {res == 8'h00, fl[1:0]};
      end
      if (op == 4'h6 || op == 4'h7) begin
        res = op[0] ? r | (8'h01 << bt) : r & ~(8'h01 << bt);
        nf = fl;
      end
      to_acc = isi || (!d && op != 4'h6 && op != 4'h7);
      ea = to_acc ? res : a;
      bus(1'b1, 10'h004, {24'h0, a});
      bus(1'b1, 10'h100 + {2'b00, rn, 2'b00}, {24'h0, r});
      bus(1'b1, 10'h008, {29'h0, fl});
      exec(op, d, bt, rn, imm);
      bus(1'b0, 10'h004, 32'h0);
      check(rd, {24'h0, ea});
      check({24'h0, acc_out}, {24'h0, ea});
      bus(1'b0, 10'h100 + {2'b00, rn, 2'b00}, 32'h0);
      check(rd, {24'h0, to_acc ? r : res});
      bus(1'b0, 10'h008, 32'h0);
      check(rd & {29'h0, mask}, {29'h0, nf & mask});
    end
  endtask

  task t_arith;
    begin
      run_op(4'h0, 1'b0, 3'h0, 6'h00, 8'h12, 8'h34, 8'h00, 3'b001);
      run_op(4'h1, 1'b1, 3'h0, 6'h3F, 8'h12, 8'h34, 8'h00, 3'b001);
      run_op(4'h1, 1'b0, 3'h0, 6'h07, 8'h80, 8'h7F, 8'h00, 3'b001);
      run_op(4'h2, 1'b1, 3'h0, 6'h01, 8'h01, 8'h77, 8'hFF, 3'b001);
      run_op(4'h3, 1'b0, 3'h0, 6'h02, 8'h0F, 8'h00, 8'h70, 3'b001);
      run_op(4'h8, 1'b1, 3'h0, 6'h05, 8'h05, 8'h03, 8'h00, 3'b001);
      run_op(4'h9, 1'b0, 3'h0, 6'h06, 8'h03, 8'h00, 8'h05, 3'b000);
      $display("test arith done");
    end
  endtask

  task t_logic;
    begin
      run_op(4'h4, 1'b1, 3'h0, 6'h10, 8'h5A, 8'hAF, 8'h00, 3'b011);
      run_op(4'h4, 1'b0, 3'h0, 6'h12, 8'hFF, 8'h3C, 8'h00, 3'b100);
      run_op(4'h5, 1'b0, 3'h0, 6'h11, 8'h5A, 8'h00, 8'hA5, 3'b011);
      for (i = 0; i < 8; i = i + 1) begin
        run_op(4'h6, 1'b0, i[2:0], 6'h20, 8'h00, 8'h5A, 8'h00, 3'b101);
        run_op(4'h7, 1'b0, i[2:0], 6'h21, 8'hFF, 8'hA5, 8'h00, 3'b010);
      end
      $display("test logic done");
    end
  endtask

  task t_unmapped;
    begin
      bus(1'b1, 10'h020, 32'hFFFFFFFF);
      bus(1'b0, 10'h020, 32'h0);
      check(rd, 32'h0);
      // done, zero and carry events of the earlier tests stay latched
      bus(1'b0, 10'h00C, 32'h0);
      check(rd, 32'h7);
      $display("test unmapped done");
    end
  endtask

  task t_status;
    begin
      check({power_down_flag, timeout_flag}, 2'b11);
      exec(4'hA, 1'b0, 3'h0, 6'h00, 8'h00);
      repeat (3) @(posedge mclk);
      check({power_down_flag, timeout_flag, n_clear}, {2'b11, 8'h01});
      exec(4'hB, 1'b0, 3'h0, 6'h00, 8'h00);
      repeat (3) @(posedge mclk);
      check({power_down_flag, timeout_flag, n_sleep}, {2'b01, 8'h01});
      bus(1'b0, 10'h008, 32'h0);
      check(rd[4:3], 2'b10);
      bus(1'b1, 10'h014, 32'h8);
      fire <= 1'b1;
      @(posedge mclk);
      fire <= 1'b0;
      repeat (4) @(posedge mclk);
      check({power_down_flag, timeout_flag, irq}, 3'b001);
      // masking then clearing the watchdog interrupt
      bus(1'b1, 10'h014, 32'h0);
      repeat (2) @(posedge mclk);
      check(irq, 1'b0);
      bus(1'b1, 10'h014, 32'h8);
      repeat (2) @(posedge mclk);
      check(irq, 1'b1);
      bus(1'b1, 10'h010, 32'hF);
      repeat (2) @(posedge mclk);
      check(irq, 1'b0);
      bus(1'b0, 10'h00C, 32'h0);
      check(rd, 32'h0);
      // sleep after a timeout brings the timeout flag back
      exec(4'hB, 1'b0, 3'h0, 6'h00, 8'h00);
      repeat (3) @(posedge mclk);
      check({power_down_flag, timeout_flag, n_sleep}, {2'b01, 8'h02});
      exec(4'hA, 1'b0, 3'h0, 6'h00, 8'h00);
      repeat (3) @(posedge mclk);
      check({power_down_flag, timeout_flag}, 2'b11);
      $display("test status done");
    end
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 10'h000;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    fire = 1'b0;
    n_mismatch = 0;
    checked = 0;
    cycles = 0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_status;
    t_arith;
    t_logic;
    t_unmapped;
    report_and_stop;
  end
endmodule // mcu_alu_flag_bitop_exec_test
